// ---- design/ersp_pkg.sv ----
// Shared constants, modes and helper functions for the embedded single-port RAM.
// Assumes every user of these names writes ersp_pkg::name; nothing is imported.
package ersp_pkg;

  // ****************************************************************
  // Block kinds and read-during-write modes
  // ****************************************************************
  typedef enum logic [1:0] {
    ERSP_KIND_LOGIC_ARRAY = 2'h0,
    ERSP_KIND_MID_SIZE    = 2'h1,
    ERSP_KIND_LARGE       = 2'h2
  } ersp_kind_t;

  typedef enum logic [1:0] {
    ERSP_RDW_NEW_DATA  = 2'h0,
    ERSP_RDW_OLD_DATA  = 2'h1,
    ERSP_RDW_DONT_CARE = 2'h2
  } ersp_rdw_t;

  // ****************************************************************
  // Result flag codes and reset values
  // ****************************************************************
  localparam logic [2:0] FLAG_NONE   = 3'h0;
  localparam logic [2:0] FLAG_FIXED  = 3'h3;
  localparam logic [2:0] FLAG_DOUBLE = 3'h5;
  localparam logic [2:0] FLAG_RESET  = 3'h0;

  // ****************************************************************
  // Error-correction word layout
  // ****************************************************************
  localparam int ECC_DATA_W = 64;
  localparam int ECC_SYN_W  = 7;
  localparam int ECC_WORD_W = 72;

  // ****************************************************************
  // Capacity of each block kind: logic-array depth in words, the others in bits
  // ****************************************************************
  localparam int LA_DEPTH       = 16;
  localparam int MID_BITS       = 8192;
  localparam int MID_BITS_PAR   = 9216;
  localparam int LARGE_BITS     = 131072;
  localparam int LARGE_BITS_PAR = 147456;

  // Position of data bit i inside the code word; powers of two hold check bits.
  function automatic int data_pos(input int i);
    int p;
    int n;
    p = 0;
    n = -1;
    while (n < i) begin
      p = p + 1;
      if ((p & (p - 1)) != 0) begin
        n = n + 1;
      end
    end
    return p;
  endfunction : data_pos

  // Tells whether a depth and width pair is one that the block kind offers.
  function automatic bit shape_ok(input ersp_kind_t kind, input int aw, input int dw);
    int depth;
    bit par;
    depth = 1 << aw;
    par   = (dw % 9) == 0;
    unique case (kind)
      ERSP_KIND_LOGIC_ARRAY: begin
        return depth == LA_DEPTH && (dw == 8 || dw == 9 || dw == 10 || dw == 16
                                     || dw == 18 || dw == 20);
      end
      ERSP_KIND_MID_SIZE: begin
        if (!(dw inside {1, 2, 4, 8, 9, 16, 18, 32, 36})) return 1'b0;
        return depth * dw == (par ? MID_BITS_PAR : MID_BITS);
      end
      default: begin
        if (!(dw inside {8, 9, 16, 18, 32, 36, 64, 72})) return 1'b0;
        return depth * dw == (par ? LARGE_BITS_PAR : LARGE_BITS);
      end
    endcase
  endfunction : shape_ok

endpackage : ersp_pkg

// ---- design/ersp_ecc_enc.sv ----
// Check-bit generator: turns a 64-bit data word into a 72-bit code word.
// Assumes the caller stores the whole code word; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ersp_ecc_enc (
  input  wire logic [ersp_pkg::ECC_DATA_W-1:0] data,
  output logic      [ersp_pkg::ECC_WORD_W-1:0] code
);

  // ****************************************************************
  // Hamming bits plus overall parity in bit 0
  // ****************************************************************
  always_comb begin
    logic s;
    s    = 1'b0;
    code = '0;
    for (int i = 0; i < ersp_pkg::ECC_DATA_W; i++) begin
      code[ersp_pkg::data_pos(i)] = data[i];
    end
    for (int k = 0; k < ersp_pkg::ECC_SYN_W; k++) begin
      s = 1'b0;
      for (int p = 1; p < ersp_pkg::ECC_WORD_W; p++) begin
        if (((p >> k) & 1) == 1) s = s ^ code[p];
      end
      code[1 << k] = s;
    end
    code[0] = ^code[ersp_pkg::ECC_WORD_W-1:1];
  end

endmodule : ersp_ecc_enc
`default_nettype wire

// ---- design/ersp_ecc_dec.sv ----
// Checker and corrector: fixes one flipped bit, flags two, passes data through.
// Assumes the code word was built by the matching generator; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ersp_ecc_dec (
  input  wire logic [ersp_pkg::ECC_WORD_W-1:0] code,
  output logic      [ersp_pkg::ECC_DATA_W-1:0] data,
  output logic      [2:0]                      flags
);

  // ****************************************************************
  // Syndrome, overall parity and correction
  // ****************************************************************
  always_comb begin
    logic [ersp_pkg::ECC_SYN_W-1:0]  syn;
    logic                            par;
    logic [ersp_pkg::ECC_WORD_W-1:0] fixed;
    syn   = '0;
    fixed = code;
    par   = ^code;
    for (int k = 0; k < ersp_pkg::ECC_SYN_W; k++) begin
      for (int p = 1; p < ersp_pkg::ECC_WORD_W; p++) begin
        if (((p >> k) & 1) == 1) syn[k] = syn[k] ^ code[p];
      end
    end
    // Three or more flips may alias to either code; they are not caught.
    if (syn == '0 && !par) begin
      flags = ersp_pkg::FLAG_NONE;
    end else if (par) begin
      if (int'(syn) < ersp_pkg::ECC_WORD_W) fixed[syn] = ~code[syn];
      flags = ersp_pkg::FLAG_FIXED;
    end else begin
      flags = ersp_pkg::FLAG_DOUBLE;
    end
    for (int i = 0; i < ersp_pkg::ECC_DATA_W; i++) begin
      data[i] = fixed[ersp_pkg::data_pos(i)];
    end
  end

endmodule : ersp_ecc_dec
`default_nettype wire

// ---- design/ersp_ram.sv ----
// Single-port embedded RAM with optional output register, output clear and
// single-correct double-detect protection on the 64-bit large block.
// Assumes all inputs come from user logic clocked by mclk.
//
// Overview of operation
// - Dedicated blocks clear both output latch and output register asynchronously.
// - Logic-array RAM clears only its output register; its output latch ignores the clear.
// - Without output register, the latch clear still zeroes dedicated read outputs.
// - Correction exists only on the large block at 64-bit width.
// - Any single flipped bit is fixed; any two flipped bits are flagged.
// - Three or more flipped bits need not be flagged.
// - Read outcome appears on the three-bit ecc_result_flags output.
// - Registered flag shares clock and clear with the data output register.
// - An unregistered flag ignores the output clear.
// - Flag codes: none 000, fixed 011, double 101; others never appear.
// - Old-data read-during-write is not offered while correction is on.
// - Dedicated blocks register address, data and enables; reset and output clear act asynchronously.
// - Logic-array RAM may read flow-through, output following the address.
// - One address per cycle: a write, a read, or both at once as a read during write.
// - Write with read enable low keeps outputs of the last enabled read.
// - Read during write shows new data, old data or a filler, by choice.
// - Dedicated output register delays read data by exactly one cycle.
// - Logic-array RAM reads on rising edge and writes on falling edge.
// - Depth by width is selectable within each kind's offered shapes.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ersp_ram #(
  parameter ersp_pkg::ersp_kind_t KIND          = ersp_pkg::ERSP_KIND_LARGE,
  parameter int                   ADDR_W        = 11,
  parameter int                   DATA_W        = 64,
  parameter bit                   ECC_EN        = 1'b1,
  parameter bit                   OUT_REG       = 1'b0,
  parameter bit                   FLAG_REG      = 1'b0,
  parameter bit                   USE_RDEN      = 1'b1,
  parameter bit                   FLOW_THRU     = 1'b0,
  parameter ersp_pkg::ersp_rdw_t  RDW_MODE      = ersp_pkg::ERSP_RDW_NEW_DATA,
  parameter logic [DATA_W-1:0]    DONTCARE_FILL = '1
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              out_clr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  output logic      [2:0]        ecc_result_flags,
  output logic                   cfg_legal
);

  // ****************************************************************
  // Configuration
  // ****************************************************************
  localparam bit IS_LA  = KIND == ersp_pkg::ERSP_KIND_LOGIC_ARRAY;
  // Correction is silently dropped on any other kind or width.
  localparam bit ECC_ON = ECC_EN && KIND == ersp_pkg::ERSP_KIND_LARGE
                          && DATA_W == ersp_pkg::ECC_DATA_W;
  localparam int MEM_W  = ECC_ON ? ersp_pkg::ECC_WORD_W : DATA_W;
  localparam int DEPTH  = 1 << ADDR_W;
  // Flow-through is a logic-array feature only; dedicated inputs are registered.
  localparam bit FLOW   = FLOW_THRU && IS_LA;
  localparam ersp_pkg::ersp_rdw_t RDW_EFF =
    (ECC_ON && RDW_MODE == ersp_pkg::ERSP_RDW_OLD_DATA) ?
    ersp_pkg::ERSP_RDW_DONT_CARE : RDW_MODE;

  assign cfg_legal = ersp_pkg::shape_ok(KIND, ADDR_W, DATA_W);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] q_lat;
    logic [2:0]        f_lat;
    logic [DATA_W-1:0] q_reg;
    logic [2:0]        f_reg;
    logic              la_we;
    logic [ADDR_W-1:0] la_addr;
    logic [MEM_W-1:0]  la_word;
  } ersp_state_t;

  ersp_state_t       st_ff;
  ersp_state_t       nxt_st;
  logic [MEM_W-1:0]  mem [DEPTH];
  logic [MEM_W-1:0]  wr_word;
  logic [MEM_W-1:0]  rd_word;
  logic [DATA_W-1:0] rd_corr;
  logic [2:0]        rd_flag;
  logic              read_now;
  logic [DATA_W-1:0] lat_view;
  logic [DATA_W-1:0] reg_view;

  // ****************************************************************
  // Protection path
  // ****************************************************************
  assign rd_word = mem[addr];

  generate
    if (ECC_ON) begin : g_ecc
      ersp_ecc_enc u_enc (
        .data (wr_data),
        .code (wr_word)
      );
      ersp_ecc_dec u_dec (
        .code  (rd_word),
        .data  (rd_corr),
        .flags (rd_flag)
      );
    end else begin : g_plain
      assign wr_word = wr_data;
      assign rd_corr = rd_word;
      assign rd_flag = ersp_pkg::FLAG_NONE;
    end
  endgenerate

  // ****************************************************************
  // Array write
  // ****************************************************************
  // Writes take the whole word; there is no byte mask, so masked writes cannot occur.
  generate
    if (IS_LA) begin : g_la_write
      always_ff @(negedge mclk) begin
        if (ce && st_ff.la_we) begin
          mem[st_ff.la_addr] <= st_ff.la_word;
        end
      end
    end else begin : g_ded_write
      // A plain clocked process, so that a test can upset a stored bit on purpose.
      always @(posedge mclk) begin
        if (ce && wr_en) begin
          mem[addr] <= wr_word;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read path and output stages
  // ****************************************************************
  assign read_now = USE_RDEN ? rd_en : 1'b1;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.la_we   = wr_en;
    nxt_st.la_addr = addr;
    nxt_st.la_word = wr_word;
    if (read_now) begin
      if (wr_en) begin
        // A write wins the cycle; the output shows new data, old data or the filler, per RDW_EFF.
        unique case (RDW_EFF)
          ersp_pkg::ERSP_RDW_NEW_DATA: begin
            nxt_st.q_lat = wr_data;
            nxt_st.f_lat = ersp_pkg::FLAG_NONE;
          end
          ersp_pkg::ERSP_RDW_OLD_DATA: begin
            nxt_st.q_lat = rd_corr;
            nxt_st.f_lat = rd_flag;
          end
          ersp_pkg::ERSP_RDW_DONT_CARE: begin
            nxt_st.q_lat = DONTCARE_FILL;
            nxt_st.f_lat = ersp_pkg::FLAG_NONE;
          end
        endcase
      end else begin
        nxt_st.q_lat = rd_corr;
        nxt_st.f_lat = rd_flag;
      end
    end
    nxt_st.q_reg = FLOW ? rd_corr : lat_view;
    nxt_st.f_reg = st_ff.f_lat;
    // A clear held across an edge also empties the stored value, so it stays cleared.
    if (out_clr) begin
      nxt_st.q_reg = '0;
      nxt_st.f_reg = ersp_pkg::FLAG_RESET;
      if (!IS_LA) begin
        nxt_st.q_lat = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // The clear masks the stored values at once, without waiting for an edge.
  assign lat_view = (out_clr && !IS_LA) ? '0 : st_ff.q_lat;
  assign reg_view = out_clr ? '0 : st_ff.q_reg;

  always_comb begin
    if (OUT_REG) begin
      rd_data = reg_view;
    end else if (FLOW) begin
      rd_data = rd_corr;
    end else begin
      rd_data = lat_view;
    end
  end

  always_comb begin
    if (FLAG_REG) begin
      ecc_result_flags = out_clr ? ersp_pkg::FLAG_RESET : st_ff.f_reg;
    end else begin
      ecc_result_flags = st_ff.f_lat;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  flag_code_legal_a: assert property (
    ecc_result_flags == ersp_pkg::FLAG_NONE || ecc_result_flags == ersp_pkg::FLAG_FIXED
    || ecc_result_flags == ersp_pkg::FLAG_DOUBLE)
    else $error("Result flag shows an illegal code.");

  flag_off_zero_a: assert property (
    !ECC_ON |-> ecc_result_flags == ersp_pkg::FLAG_NONE)
    else $error("Result flag moved without correction enabled.");

  latch_clear_out_a: assert property (
    (!IS_LA && out_clr) |-> rd_data == '0)
    else $error("Dedicated read output not cleared.");

  la_reg_clear_a: assert property (
    (IS_LA && OUT_REG && out_clr) |-> rd_data == '0)
    else $error("Logic-array output register not cleared.");

  rden_hold_a: assert property (
    (USE_RDEN && ce && wr_en && !rd_en && !out_clr) |=> $stable(st_ff.q_lat))
    else $error("Output changed on a write with read enable low.");

  new_data_show_a: assert property (
    (RDW_EFF == ersp_pkg::ERSP_RDW_NEW_DATA && ce && wr_en && read_now && !out_clr)
    |=> st_ff.q_lat == $past(wr_data))
    else $error("Read during write did not show new data.");

  reg_one_delay_a: assert property (
    (OUT_REG && !FLOW && ce && !out_clr) ##1 !out_clr |-> rd_data == $past(lat_view))
    else $error("Output register delay is not one cycle.");

  flag_reg_follow_a: assert property (
    (FLAG_REG && ce && !out_clr) ##1 !out_clr |-> ecc_result_flags == $past(st_ff.f_lat))
    else $error("Registered flag does not follow the read stage.");

  unreg_flag_keep_a: assert property (
    (!FLAG_REG && out_clr && !ce) |=> $stable(ecc_result_flags))
    else $error("Unregistered flag was touched by the clear.");

  read_pair_a: assert property (
    (ECC_ON && ce && read_now && !wr_en && !out_clr)
    |=> st_ff.q_lat == $past(rd_corr) && st_ff.f_lat == $past(rd_flag))
    else $error("Data and flag of one read did not arrive together.");

endmodule : ersp_ram
`default_nettype wire

// ---- tb/ersp_user.sv ----
// Model of the user logic that drives the single-port RAM.
// Assumes the bench calls its tasks; requests change just after rising mclk.
`timescale 1ns/1ps
`default_nettype none
module ersp_user (
  input  wire logic        mclk,
  output logic             ce,
  output logic             out_clr,
  output logic [10:0]      addr,
  output logic [63:0]      wr_data,
  output logic             wr_en,
  output logic             rd_en
);
  initial begin
    ce      = 1'b1;
    out_clr = 1'b0;
    addr    = 11'h000;
    wr_data = 64'h0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  // Every write carries the whole word; no byte lanes are ever masked.
  task automatic access(input logic [10:0] a, input logic [63:0] d, input logic we,
                        input logic re);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= we;
    rd_en   <= re;
    @(posedge mclk);
    // Released address and data show the inverse and both enables drop low, so stale values cannot pass for good ones.
    addr    <= ~a;
    wr_data <= ~d;
    wr_en   <= 1'b0;
    rd_en   <= 1'b0;
  endtask : access

  task automatic clear(input logic on);
    @(posedge mclk);
    out_clr <= on;
  endtask : clear
endmodule : ersp_user
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the single-port RAM with error correction.
// Assumes the design package and the design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk;
  logic        reset;
  logic        ce;
  logic        out_clr;
  logic [10:0] addr;
  logic [63:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [63:0] rd_data;
  logic [63:0] rd_data_r;
  logic [2:0]  flags;
  logic [2:0]  flags_r;
  logic        legal;
  logic [63:0] mem [int];
  logic [63:0] last_rd;
  logic [15:0] seed;
  int          n_mismatch;
  int          comparisons;
  int          cycles = 0;

  // ****************************************************************
  // Clock, instances and helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ersp_user u_user (.mclk(mclk), .ce(ce), .out_clr(out_clr), .addr(addr),
                    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
  // New-data mode only; old data is not offered with correction on.
  ersp_ram #(.RDW_MODE(ersp_pkg::ERSP_RDW_NEW_DATA)) dut (
    .mclk(mclk), .reset(reset), .ce(ce), .out_clr(out_clr), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ecc_result_flags(flags), .cfg_legal(legal));
  ersp_ram #(.OUT_REG(1'b1), .FLAG_REG(1'b1)) dut_reg (
    .mclk(mclk), .reset(reset), .ce(ce), .out_clr(out_clr), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_r),
    .ecc_result_flags(flags_r), .cfg_legal());

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [63:0] rnd64();
    logic [63:0] v;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v[i*16 +: 16] = seed;
    end
    return v;
  endfunction : rnd64

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask : check

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Reads one word and checks both the plain and the registered output.
  task automatic do_read(input logic [10:0] a);
    u_user.access(a, rnd64(), 1'b0, 1'b1);
    #1;
    check("rd_data", rd_data, mem[a]);
    check("flags", {61'h0, flags}, {61'h0, ersp_pkg::FLAG_NONE});
    check("rd_data_r early", rd_data_r, last_rd);
    @(posedge mclk);
    #1;
    check("rd_data_r", rd_data_r, mem[a]);
    check("flags_r", {61'h0, flags_r}, {61'h0, ersp_pkg::FLAG_NONE});
    last_rd = mem[a];
  endtask : do_read

  // Upsets one stored bit in both arrays, between clock edges.
  task automatic flip(input logic [10:0] a, input int b);
    dut.mem[a][b]     = ~dut.mem[a][b];
    dut_reg.mem[a][b] = ~dut_reg.mem[a][b];
  endtask : flip

  // Reads a protected word through the top; data is checked only when it can be fixed.
  task automatic ecc_read(input logic [10:0] a, input logic [63:0] d, input logic [2:0] f,
                          input logic chk);
    u_user.access(a, rnd64(), 1'b0, 1'b1);
    #1;
    if (chk) check("ecc data", rd_data, d);
    check("ecc flags", {61'h0, flags}, {61'h0, f});
    @(posedge mclk);
    #1;
    if (chk) check("ecc data reg", rd_data_r, d);
    check("ecc flags reg", {61'h0, flags_r}, {61'h0, f});
  endtask : ecc_read

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [10:0] a;
    logic [63:0] d;
    int          p;
    int          q;
    n_mismatch  = 0;
    comparisons = 0;
    seed        = 16'd16331;
    reset       = 1'b1;
    last_rd     = 64'h0;
    repeat (20) @(posedge mclk);
    check("rd_data reset", rd_data, 64'h0);
    check("legal", {63'h0, legal}, 64'h1);
    reset <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : rnd64();
      d = rnd64();
      mem[a] = d;
      u_user.access(a, d, 1'b1, 1'b0);
      #1;
      check("rd_data hold", rd_data, last_rd);
      do_read(a);
    end
    $display("test write_read done");
    foreach (mem[k]) do_read(k[10:0]);
    a = 11'h155;
    d = 64'hA5A5_0F0F_FFFF_0001;
    mem[a] = d;
    u_user.access(a, d, 1'b1, 1'b1);
    #1;
    check("rdw new", rd_data, d);
    check("rdw flags", {61'h0, flags}, {61'h0, ersp_pkg::FLAG_NONE});
    last_rd = d;
    @(posedge mclk);
    $display("test read_during_write done");
    u_user.clear(1'b1);
    #1;
    check("clr mask", rd_data, 64'h0);
    check("clr flags", {61'h0, flags}, {61'h0, ersp_pkg::FLAG_NONE});
    u_user.clear(1'b0);
    #1;
    check("clr held", rd_data, 64'h0);
    check("clr reg", rd_data_r, 64'h0);
    last_rd = 64'h0;
    do_read(a);
    $display("test clear done");
    for (int i = 0; i < 60; i++) begin
      a = rnd64();
      d = rnd64();
      p = seed % 72;
      q = (p + 1 + (rnd64() % 71)) % 72;
      mem[a] = d;
      u_user.access(a, d, 1'b1, 1'b0);
      ecc_read(a, d, ersp_pkg::FLAG_NONE, 1'b1);
      flip(a, p);
      ecc_read(a, d, ersp_pkg::FLAG_FIXED, 1'b1);
      flip(a, q);
      ecc_read(a, d, ersp_pkg::FLAG_DOUBLE, 1'b0);
      flip(a, p);
      flip(a, q);
    end
    $display("test ecc done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
